// file: src/chrc_pkg.sv
package chrc_pkg;
  // csr address of the power-management control register
  localparam logic [11:0] CHRC_PMC_ADDR = 12'h7C6;
  // field positions
  localparam int CHRC_HALT_BIT = 0;
  localparam int CHRC_HALTIE_BIT = 1;
  // reset values
  localparam logic CHRC_HALTIE_RST = 1'b1;
  localparam logic CHRC_HALT_RST = 1'b0;
  // quiesce time for a firmware halt, in core cycles
  localparam int CHRC_QUIESCE_CYC = 4;

  // core activity states
  typedef enum logic [1:0] {
    CHRC_RUN = 2'b00,
    CHRC_PWR_HALT = 2'b01,
    CHRC_DBG_HALT = 2'b10
  } chrc_state_e;

  // csr access from the core pipeline
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [11:0] addr;
    logic [31:0] wdata;
  } chrc_csr_req_s;

  // wake sources for the power-halted state
  typedef struct packed {
    logic pmu_run;
    logic top_wake;
    logic timer;
    logic int_timer;
    logic nmi;
  } chrc_wake_s;
endpackage : chrc_pkg

// file: src/chrc_quiesce.sv
`timescale 1ns/1ps
// counts down the pipeline drain before a graceful halt is reported
module chrc_quiesce #(
  parameter int CYCLES = chrc_pkg::CHRC_QUIESCE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start,
  input wire logic abort,
  output logic done
);
  import chrc_pkg::*;
  initial begin
    if (CYCLES < 1 || CYCLES > 255) $error("quiesce cycles out of range");
  end
  logic [7:0] cnt_q; // cycles left, zero when idle
  logic busy_q; // drain in progress
  logic done_q; // one-cycle completion pulse
  wire last_w = busy_q && (cnt_q == 8'h01);
  // countdown process
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= last_w && !abort;
      if (abort) begin
        busy_q <= 1'b0;
        cnt_q <= 8'h00;
      end else if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= 8'(CYCLES);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
        busy_q <= !last_w;
      end
    end
  end
  assign done = done_q;
endmodule : chrc_quiesce

// file: src/chrc_core_halt_run.sv
`timescale 1ns/1ps
// Operation
// - mpc halt while running enters debug halt
// - already debug halted: acknowledge mpc halt immediately
// - mpc run waits for debugger operation end
// - debugger resume alone keeps core halted
// - dual halt needs both run requests
// - run ack only after running, status low
// - power halt wakes on five events
// - firmware halt quiesces before halted indication
// - dma serviced in both halted states
// - halted: only enabled top wake honoured
// - pending interrupts taken after returning to run
// - reserved bits read zero, legal values
// - halt bit write one starts power halt
// - haltie set enables interrupts on halt entry
// - haltie write alone leaves enable unchanged
// - enable set on entry stays set
// - debug mode ignores halt, haltie no effect
// - register at 0x7C6, haltie resets one
// - four-phase request/acknowledge handshakes
// - reset start-state picks running or debug halt
module chrc_core_halt_run #(
  parameter int QUIESCE_CYC = chrc_pkg::CHRC_QUIESCE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reset_run_req,
  input wire logic mpc_halt_req,
  output logic mpc_halt_ack,
  input wire logic mpc_run_req,
  output logic mpc_run_ack,
  output logic debug_mode_status,
  input wire logic dbg_halt_req,
  input wire logic dbg_resume_req,
  input wire logic dbg_op_busy,
  input wire chrc_pkg::chrc_csr_req_s csr_req,
  output logic [31:0] csr_rdata,
  input wire chrc_pkg::chrc_wake_s wake,
  input wire logic meie,
  input wire logic ext_int_pending,
  input wire logic mie_clr,
  output logic mie,
  output logic fw_halted,
  output logic core_run_en,
  output logic ext_int_take,
  input wire logic dma_req,
  output logic dma_grant
);
  import chrc_pkg::*;

  chrc_state_e state_q, state_d; // core activity state
  logic dbg_hold_q; // on-chip debugger holds the halt
  logic mpc_hold_q; // multicore controller holds the halt
  logic halt_ack_q; // halt acknowledge
  logic run_ack_q; // run acknowledge
  logic run_pend_q; // accepted run request not yet answered
  logic haltie_q; // stored halt-interrupt-enable
  logic mie_q; // global interrupt enable
  logic fw_halted_q; // graceful power halt reported
  logic quiesce_q; // firmware halt is draining
  logic [31:0] rdata_q; // read data register
  logic start_q; // first cycle after reset release
  logic take_q; // external interrupt taken
  logic grant_q; // dma grant
  logic quiesce_done;

  // csr decode
  wire csr_hit_w = (csr_req.addr == CHRC_PMC_ADDR);
  wire csr_wr_w = csr_req.wr_en && csr_hit_w;
  wire in_dbg_w = (state_q == CHRC_DBG_HALT);
  // halt bit is a one-cycle pulse with no storage
  wire fw_halt_pulse_w = csr_wr_w && csr_req.wdata[CHRC_HALT_BIT] && !in_dbg_w;
  wire fw_halt_start_w = fw_halt_pulse_w && (state_q == CHRC_RUN) && !quiesce_q;
  // enable set atomically with the halt
  wire mie_set_w = fw_halt_start_w && (csr_wr_w ? csr_req.wdata[CHRC_HALTIE_BIT] : haltie_q);
  // top wake needs both interrupt enables
  wire top_wake_ok_w = wake.top_wake && mie_q && meie;
  wire pwr_wake_w = wake.pmu_run || top_wake_ok_w || wake.timer || wake.int_timer || wake.nmi;
  // debugger and controller holds
  wire mpc_halt_new_w = mpc_halt_req && !halt_ack_q;
  wire mpc_run_new_w = mpc_run_req && !run_ack_q && !run_pend_q;
  wire dbg_hold_d_w = dbg_halt_req ? 1'b1 : ((dbg_resume_req && !dbg_op_busy) ? 1'b0 : dbg_hold_q);
  wire mpc_hold_d_w = mpc_halt_new_w ? 1'b1 : (mpc_run_new_w ? 1'b0 : mpc_hold_q);
  wire leave_dbg_w = in_dbg_w && !dbg_hold_d_w && !mpc_hold_d_w;

  // next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      CHRC_RUN: begin
        if (dbg_halt_req || mpc_halt_new_w) begin
          state_d = CHRC_DBG_HALT;
        end else if (quiesce_done) begin
          state_d = CHRC_PWR_HALT;
        end
      end
      CHRC_PWR_HALT: begin
        if (dbg_halt_req || mpc_halt_new_w) begin
          state_d = CHRC_DBG_HALT;
        end else if (pwr_wake_w) begin
          state_d = CHRC_RUN;
        end
      end
      CHRC_DBG_HALT: begin
        if (leave_dbg_w) begin
          state_d = CHRC_RUN;
        end
      end
      default: begin
        state_d = CHRC_RUN;
      end
    endcase
  end

  // state and hold registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CHRC_RUN;
      dbg_hold_q <= 1'b0;
      mpc_hold_q <= 1'b0;
      start_q <= 1'b1;
    end else begin
      start_q <= 1'b0;
      if (start_q && !reset_run_req) begin
        // reset strap caught after release; only mpc run frees it
        state_q <= CHRC_DBG_HALT;
        mpc_hold_q <= 1'b1;
        dbg_hold_q <= 1'b0;
      end else begin
        state_q <= state_d;
        dbg_hold_q <= dbg_hold_d_w;
        mpc_hold_q <= mpc_hold_d_w;
      end
    end
  end

  // handshake acknowledges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      halt_ack_q <= 1'b0;
      run_ack_q <= 1'b0;
      run_pend_q <= 1'b0;
    end else begin
      // ack once debug halted, whether new or already there
      halt_ack_q <= mpc_halt_req && (in_dbg_w || halt_ack_q);
      if (mpc_run_new_w) begin
        run_pend_q <= 1'b1;
      end else if (run_pend_q && state_q == CHRC_RUN) begin
        run_pend_q <= 1'b0;
      end
      // ack after running with status dropped
      if (!mpc_run_req) begin
        run_ack_q <= 1'b0;
      end else if ((run_pend_q || run_ack_q) && state_q == CHRC_RUN) begin
        run_ack_q <= 1'b1;
      end
    end
  end

  // firmware halt, enable and csr registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      haltie_q <= CHRC_HALTIE_RST;
      mie_q <= 1'b0;
      quiesce_q <= CHRC_HALT_RST;
      fw_halted_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (csr_wr_w) begin
        haltie_q <= csr_req.wdata[CHRC_HALTIE_BIT];
      end
      // set from halt entry wins over a clear
      if (mie_set_w) begin
        mie_q <= 1'b1;
      end else if (mie_clr) begin
        mie_q <= 1'b0;
      end
      if (fw_halt_start_w) begin
        quiesce_q <= 1'b1;
      end else if (quiesce_done || state_q != CHRC_RUN) begin
        quiesce_q <= 1'b0;
      end
      fw_halted_q <= (state_d == CHRC_PWR_HALT);
      // reserved bits and halt bit read zero
      rdata_q <= (csr_req.rd_en && csr_hit_w) ? {30'h0, haltie_q, 1'b0} : 32'h0000_0000;
    end
  end

  // interrupt take and dma service
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      take_q <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      take_q <= ext_int_pending && mie_q && meie && (state_d == CHRC_RUN) && !quiesce_q;
      grant_q <= dma_req;
    end
  end

  chrc_quiesce #(
    .CYCLES(QUIESCE_CYC)
  ) u_quiesce (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(fw_halt_start_w),
    .abort(dbg_halt_req || mpc_halt_new_w),
    .done(quiesce_done)
  );

  // debug status registered from next state
  logic dbg_stat_q;
  logic run_en_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dbg_stat_q <= 1'b0;
      run_en_q <= 1'b0;
    end else begin
      dbg_stat_q <= (state_d == CHRC_DBG_HALT) || (start_q && !reset_run_req);
      run_en_q <= (state_d == CHRC_RUN) && !quiesce_q && !(start_q && !reset_run_req);
    end
  end

  assign mpc_halt_ack = halt_ack_q;
  assign mpc_run_ack = run_ack_q;
  assign debug_mode_status = dbg_stat_q;
  assign csr_rdata = rdata_q;
  assign mie = mie_q;
  assign fw_halted = fw_halted_q;
  assign core_run_en = run_en_q;
  assign ext_int_take = take_q;
  assign dma_grant = grant_q;
endmodule : chrc_core_halt_run

// file: dv/chrc_core_halt_run_properties.sv
`timescale 1ns/1ps
// watches halt and run arbitration at the core's ports
module chrc_core_halt_run_properties
  import chrc_pkg::*;
#(
  parameter int QUIESCE_CYC = CHRC_QUIESCE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic mpc_halt_req,
  input wire logic mpc_halt_ack,
  input wire logic mpc_run_req,
  input wire logic mpc_run_ack,
  input wire logic debug_mode_status,
  input wire chrc_pkg::chrc_csr_req_s csr_req,
  input wire logic [31:0] csr_rdata,
  input wire chrc_pkg::chrc_wake_s wake,
  input wire logic meie,
  input wire logic mie,
  input wire logic fw_halted,
  input wire logic dma_req,
  input wire logic dma_grant
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // control register strobes and the combined wake condition
  wire pmc_wr = csr_req.wr_en && csr_req.addr == CHRC_PMC_ADDR;
  wire pmc_rd = csr_req.rd_en && csr_req.addr == CHRC_PMC_ADDR;
  wire wake_any = wake.pmu_run || wake.timer || wake.int_timer || wake.nmi || (wake.top_wake && meie && mie);
  logic [7:0] since_wr_q; // cycles since the last register write
  // saturating age of the last write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) since_wr_q <= 8'h00;
    else if (pmc_wr) since_wr_q <= 8'h00;
    else if (since_wr_q != 8'hFF) since_wr_q <= since_wr_q + 8'h01;
  end
  AST_HALT_ACK: assert property ($rose(mpc_halt_req) |-> ##[1:3] (mpc_halt_ack && debug_mode_status))
    else $error("halt request not acknowledged in debug halt");
  AST_HALT_DROP: assert property (mpc_halt_ack && !mpc_halt_req |=> !mpc_halt_ack)
    else $error("halt acknowledge held after request fell");
  AST_RUN_ACK: assert property (mpc_run_ack |-> !debug_mode_status)
    else $error("run acknowledge while still in debug halt");
  AST_RUN_DROP: assert property (mpc_run_ack && !mpc_run_req |=> !mpc_run_ack)
    else $error("run acknowledge held after request fell");
  AST_DMA: assert property ($past(reset_n) |-> dma_grant == $past(dma_req))
    else $error("dma grant does not follow request");
  AST_READ: assert property (pmc_rd |=> csr_rdata[31:2] == 30'h0 && !csr_rdata[0])
    else $error("reserved or halt bit reads nonzero");
  AST_IE_ENTRY: assert property (pmc_wr && csr_req.wdata[1:0] == 2'b11 && !debug_mode_status && !fw_halted |=> mie)
    else $error("interrupt enable not set on halt entry");
  AST_IE_ONLY: assert property (pmc_wr && csr_req.wdata[1:0] == 2'b10 && !mie |=> !mie)
    else $error("enable changed without halt");
  AST_DBG_WR: assert property (pmc_wr && debug_mode_status |=> $stable(mie) && !fw_halted)
    else $error("register write acted in debug mode");
  AST_QUIESCE: assert property ($rose(fw_halted) |-> since_wr_q > QUIESCE_CYC)
    else $error("halted reported before quiesce time");
  AST_WAKE: assert property (fw_halted && wake_any |-> ##[1:4] !fw_halted)
    else $error("power halt did not wake");
  AST_TOP_MASKED: assert property (fw_halted && wake == 5'h08 && !(meie && mie) |=> fw_halted)
    else $error("disabled top wake left power halt");
  COV_RUN: cover property (mpc_run_ack);
  COV_WAKE: cover property (fw_halted ##1 !fw_halted);
  COV_READ: cover property (pmc_rd ##1 csr_rdata[1]);
endmodule : chrc_core_halt_run_properties

bind chrc_core_halt_run chrc_core_halt_run_properties #(.QUIESCE_CYC(QUIESCE_CYC)) chk_i (.*);

// file: dv/chrc_mpc_model.sv
`timescale 1ns/1ps
// multi-core controller: one request at a time, four-phase
module chrc_mpc_model (
  input wire logic clk_sys,
  input wire logic mpc_halt_ack,
  input wire logic mpc_run_ack,
  output logic mpc_halt_req,
  output logic mpc_run_req
);
  initial {mpc_halt_req, mpc_run_req} = 2'b00;
  // raise, hold until ack, linger lag cycles, drop, wait for ack low
  task automatic send(input logic run, input int lag);
    int cyc;
    cyc = 0;
    @(posedge clk_sys);
    if (run) mpc_run_req <= 1'b1;
    else mpc_halt_req <= 1'b1;
    do begin
      @(posedge clk_sys);
      cyc++;
    end while ((run ? mpc_run_ack : mpc_halt_ack) !== 1'b1 && cyc < 99);
    repeat (lag) @(posedge clk_sys);
    {mpc_halt_req, mpc_run_req} <= 2'b00;
    while ((mpc_halt_ack | mpc_run_ack) !== 1'b0 && cyc < 99) begin
      @(posedge clk_sys);
      cyc++;
    end
  endtask : send
endmodule : chrc_mpc_model

// file: dv/core_halt_run_control_tb.sv
`timescale 1ns/1ps
module core_halt_run_control_tb;
  import chrc_pkg::*;
  logic clk_sys, reset_n, reset_run_req, mpc_halt_req, mpc_halt_ack, mpc_run_req, mpc_run_ack;
  logic debug_mode_status, dbg_halt_req, dbg_resume_req, dbg_op_busy, meie, ext_int_pending;
  logic mie_clr, mie, fw_halted, core_run_en, ext_int_take, dma_req, dma_grant;
  logic [31:0] csr_rdata; // register read data
  chrc_csr_req_s csr_req; // register access strobe
  chrc_wake_s wake; // wake sources
  int n_mismatch, total_checks;
  chrc_core_halt_run #(.QUIESCE_CYC(2)) uut (.*);
  chrc_mpc_model mpc (.*);
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // dma traffic in every state
  always @(posedge clk_sys) dma_req <= ~dma_req;
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : look
  // one register access, write or read
  task automatic csr(input logic wr, input logic [31:0] d);
    @(posedge clk_sys);
    csr_req <= '{wr_en: wr, rd_en: !wr, addr: CHRC_PMC_ADDR, wdata: d};
    @(posedge clk_sys);
    csr_req <= '0;
    #1;
  endtask : csr
  // debugger halt or resume pulse
  task automatic dbg(input logic h);
    @(posedge clk_sys);
    if (h) dbg_halt_req <= 1'b1;
    else dbg_resume_req <= 1'b1;
    @(posedge clk_sys);
    {dbg_halt_req, dbg_resume_req} <= 2'b00;
  endtask : dbg
  task automatic wait_fw(input logic v);
    int cyc;
    cyc = 0;
    while (fw_halted !== v && cyc < 40) begin
      look(1);
      cyc++;
    end
  endtask : wait_fw
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // watchdog
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {reset_n, reset_run_req, dbg_halt_req, dbg_resume_req, dbg_op_busy} = 5'h00;
    {meie, ext_int_pending, mie_clr, dma_req} = 4'h0;
    csr_req = '0;
    wake = '0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    look(3);
    chk("start_dbg", debug_mode_status, 1);
    mpc.send(1, 2);
    chk("strap_run", debug_mode_status, 0);
    $display("strap test done");
    dbg(1);
    mpc.send(0, 0);
    chk("held", debug_mode_status, 1);
    @(posedge clk_sys) dbg_op_busy <= 1'b1;
    fork
      mpc.send(1, 0);
    join_none
    look(8);
    chk("busy_hold", debug_mode_status, 1);
    chk("no_run_ack", mpc_run_ack, 0);
    @(posedge clk_sys) dbg_op_busy <= 1'b0;
    dbg(0);
    wait fork;
    chk("both_run", debug_mode_status, 0);
    mpc.send(0, 1);
    dbg(0);
    look(4);
    chk("resume_only", debug_mode_status, 1);
    csr(1, 32'h3);
    look(6);
    chk("dbg_wr_halt", fw_halted, 0);
    chk("dbg_wr_ie", mie, 0);
    mpc.send(1, 0);
    chk("mpc_run", debug_mode_status, 0);
    $display("debug test done");
    csr(0, 0);
    chk("pmc_rst", csr_rdata, 32'h2);
    csr(1, 32'h2);
    look(4);
    chk("ie_only", mie, 0);
    csr(1, 32'h1);
    wait_fw(1);
    chk("fw_halt", fw_halted, 1);
    chk("ie_clear", mie, 0);
    csr(0, 0);
    chk("pmc_rd", csr_rdata, 32'h0);
    @(posedge clk_sys) {wake.top_wake, meie} <= 2'b11;
    look(5);
    chk("top_masked", fw_halted, 1);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys) wake <= chrc_wake_s'(5'h01 << i);
      wait_fw(0);
      chk("woken", fw_halted, 0);
      chk("ie_kept", mie, i > 0);
      @(posedge clk_sys) wake <= '0;
      csr(1, 32'h3);
      wait_fw(1);
      chk("ie_entry", mie, 1);
    end
    @(posedge clk_sys) ext_int_pending <= 1'b1;
    look(4);
    chk("halt_no_int", ext_int_take, 0);
    chk("halt_no_run", core_run_en, 0);
    @(posedge clk_sys) wake <= '{pmu_run: 1'b1, default: 1'b0};
    wait_fw(0);
    look(2);
    chk("int_taken", ext_int_take, 1);
    chk("run_en", core_run_en, 1);
    @(posedge clk_sys) {wake, ext_int_pending, mie_clr} <= 7'h01;
    @(posedge clk_sys) mie_clr <= 1'b0;
    look(1);
    chk("mie_clr", mie, 0);
    $display("power halt test done");
    wrap_up();
  end
endmodule : core_halt_run_control_tb
